// ===== pteow_pkg.sv
// package: constants for the event output waveform block
package pteow_pkg;
  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;    // enable, selector, soft reset
  localparam logic [3:0] ADDR_TIME = 4'h1;    // target time low word
  localparam logic [3:0] ADDR_PWID = 4'h2;    // pulse width
  localparam logic [3:0] ADDR_CWID = 4'h3;    // cycle or bit width
  localparam logic [3:0] ADDR_CCNT = 4'h4;    // cycle count and pattern
  localparam logic [3:0] ADDR_ITER = 4'h5;    // tail repeat count
  localparam logic [3:0] ADDR_STAT = 4'h6;    // status readback
  // control word fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_NOW_BIT = 1;
  localparam int CTRL_CASC_BIT = 2;
  localparam int CTRL_TAIL_BIT = 3;
  localparam int CTRL_SRST_BIT = 4;
  localparam int CTRL_SEL_LO = 20;
  localparam int CTRL_SEL_HI = 22;
  localparam int CCNT_CNT_LO = 16;
  localparam int PAT_W = 16;
  localparam logic [2:0] SEL_RESET = 3'h0;
  localparam logic [15:0] ITER_RESET = 16'h0000;
  // ----------------------------------------------------------------------
  // waveform selector codes
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    WAVE_NEG_EDGE = 3'h0,
    WAVE_POS_EDGE = 3'h1,
    WAVE_NEG_PULSE = 3'h2,
    WAVE_POS_PULSE = 3'h3,
    WAVE_NEG_PERIOD = 3'h4,
    WAVE_POS_PERIOD = 3'h5,
    WAVE_PATTERN = 3'h6,
    WAVE_RESERVED = 3'h7
  } pteow_wave_t;
endpackage : pteow_pkg

// ===== pteow_timer.sv
// module: down-counting phase timer
`timescale 1ns/100ps
`default_nettype none
module pteow_timer #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // control
  input wire logic load,
  input wire logic [W-1:0] len,
  // status
  output logic expired
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;

  // ----------------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------------
  // a zero length still lasts one cycle
  assign cnt_next = load ? ((len == '0) ? W'(1) : len) :
                    (cnt_reg != '0) ? cnt_reg - W'(1) : cnt_reg;
  // no load term here: the caller's load decision reads this flag
  assign expired = (cnt_reg == W'(1));

  // count register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : pteow_timer
`default_nettype wire

// ===== pteow_core.sv
// module: event output waveform generator with register port
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - three-bit waveform selector, reset to zero, picks waveform
// - start only when enabled and target time reached
// - code 000: drive high idle to low, stay low
// - code 001: positive edge event, output stays high
// - code 010: one low pulse of pulse width, back high
// - code 011: one high pulse of pulse width, back low
// - code 100: low phase periodic, count cycles, zero runs forever
// - code 101: high phase periodic, count cycles, zero runs forever
// - code 110: 16-bit pattern MSB first, looped, bit count, zero forever
// - 16-bit tail repeat count, pattern output count plus one times
// - cascade without tail ignores repeat count, repeats forever
// - fire-now fires at once when target already past
// - soft reset stops an endless loop
module pteow_core
  import pteow_pkg::*;
#(
  parameter int TW = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // local system time
  input wire logic [TW-1:0] sys_time,
  // event output
  output logic event_out
);
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACT = 4'b0010,
    ST_REST = 4'b0100,
    ST_DONE = 4'b1000
  } pteow_state_t;

  pteow_state_t state_reg, state_next;
  logic event_output_enable_reg;
  logic now_reg;
  logic casc_reg;
  logic tail_reg;
  logic output_unit_soft_reset_reg;
  logic [2:0] sel_reg;
  logic [TW-1:0] target_reg;
  logic [31:0] pwid_reg;
  logic [31:0] cwid_reg;
  logic [15:0] ccnt_reg;
  logic [PAT_W-1:0] pat_reg;
  logic [15:0] iter_reg;
  logic [31:0] rdata_reg;
  logic out_reg, out_next;
  logic [15:0] done_cnt_reg, done_cnt_next;
  logic [3:0] bit_idx_reg, bit_idx_next;
  logic [15:0] iter_cnt_reg, iter_cnt_next;
  logic ahead_seen_reg;

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  function automatic logic idle_level(input logic [2:0] sel);
    // positive pulse and positive periodic rest low, others rest high
    idle_level = !(sel == WAVE_POS_PULSE || sel == WAVE_POS_PERIOD);
  endfunction : idle_level

  wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  wire wr_any_cfg = reg_wr && (reg_addr != ADDR_STAT);
  wire time_hit = (sys_time >= target_reg);
  wire time_eq = (sys_time == target_reg);
  // a target already behind the clock at arming fires only with fire-now
  wire time_past = (sys_time > target_reg) && now_reg;
  wire fire = event_output_enable_reg &&
              (time_eq || (time_hit && ahead_seen_reg) || time_past);
  wire is_period = (sel_reg == WAVE_NEG_PERIOD) ||
                   (sel_reg == WAVE_POS_PERIOD);
  wire is_pulse = (sel_reg == WAVE_NEG_PULSE) ||
                  (sel_reg == WAVE_POS_PULSE);
  wire is_pat = (sel_reg == WAVE_PATTERN);
  wire idle_lvl = idle_level(sel_reg);
  // repeat count only honoured on a tail unit of a chain
  wire iter_limited = casc_reg && tail_reg;
  wire count_inf = (ccnt_reg == 16'h0000);

  // ----------------------------------------------------------------------
  // arming
  // ----------------------------------------------------------------------
  // remembers that the target lay ahead while armed, so a target that the
  // clock has already passed stays quiet unless fire-now is set
  wire arm_clr = reg_wr && (reg_addr == ADDR_CTRL || reg_addr == ADDR_TIME);
  wire ahead_now = event_output_enable_reg && (sys_time < target_reg);
  wire ahead_seen_next = !arm_clr && (ahead_seen_reg || ahead_now);

  // ahead flag; any control or target write starts it afresh
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ahead_seen_reg <= 1'b0;
    end else begin
      ahead_seen_reg <= ahead_seen_next;
    end
  end

  // ----------------------------------------------------------------------
  // phase timers
  // ----------------------------------------------------------------------
  logic act_load, rest_load;
  logic act_exp, rest_exp;
  logic [31:0] act_len, rest_len;

  // active phase is pulse width, or a whole bit for patterns
  assign act_len = is_pat ? cwid_reg : pwid_reg;
  // rest phase fills the cycle; cycle shorter than pulse gives one cycle
  assign rest_len = (cwid_reg > pwid_reg) ? cwid_reg - pwid_reg : 32'h1;

  pteow_timer #(.W(32)) u_act (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .load(act_load),
    .len(act_len),
    .expired(act_exp)
  );

  pteow_timer #(.W(32)) u_rest (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .load(rest_load),
    .len(rest_len),
    .expired(rest_exp)
  );

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  // next state, output level and counters
  always_comb begin
    state_next = state_reg;
    out_next = out_reg;
    done_cnt_next = done_cnt_reg;
    bit_idx_next = bit_idx_reg;
    iter_cnt_next = iter_cnt_reg;
    act_load = 1'b0;
    rest_load = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        out_next = idle_lvl;
        done_cnt_next = 16'h0000;
        bit_idx_next = 4'(PAT_W - 1);
        iter_cnt_next = 16'h0000;
        if (fire) begin
          act_load = 1'b1;
          case (sel_reg)
            WAVE_NEG_EDGE: begin
              out_next = 1'b0;
              state_next = ST_DONE;
            end
            WAVE_POS_EDGE: begin
              out_next = 1'b1;
              state_next = ST_DONE;
            end
            WAVE_NEG_PULSE, WAVE_POS_PULSE: begin
              out_next = !idle_lvl;
              state_next = ST_ACT;
            end
            WAVE_NEG_PERIOD, WAVE_POS_PERIOD: begin
              out_next = !idle_lvl;
              state_next = ST_ACT;
            end
            WAVE_PATTERN: begin
              out_next = pat_reg[PAT_W-1];
              state_next = ST_ACT;
            end
            default: begin
              out_next = idle_lvl;
              state_next = ST_IDLE;
            end
          endcase
        end
      end
      ST_ACT: begin
        if (act_exp) begin
          if (is_pulse) begin
            out_next = idle_lvl;
            state_next = ST_DONE;
          end else if (is_period) begin
            out_next = idle_lvl;
            rest_load = 1'b1;
            state_next = ST_REST;
          end else if (is_pat) begin
            // one bit done; count bits and whole pattern passes
            done_cnt_next = done_cnt_reg + 16'h1;
            bit_idx_next = bit_idx_reg - 4'h1;
            if (bit_idx_reg == 4'h0) begin
              iter_cnt_next = iter_cnt_reg + 16'h1;
            end
            if ((!count_inf && done_cnt_next == ccnt_reg) ||
                (iter_limited && bit_idx_reg == 4'h0 &&
                 iter_cnt_reg == iter_reg)) begin
              state_next = ST_DONE;
            end else begin
              out_next = pat_reg[bit_idx_next];
              act_load = 1'b1;
            end
          end else begin
            state_next = ST_DONE;
          end
        end
      end
      ST_REST: begin
        if (rest_exp) begin
          done_cnt_next = done_cnt_reg + 16'h1;
          if (!count_inf && done_cnt_next == ccnt_reg) begin
            state_next = ST_DONE;
          end else begin
            out_next = !idle_lvl;
            act_load = 1'b1;
            state_next = ST_ACT;
          end
        end
      end
      ST_DONE: begin
        // hold final level until software reconfigures
        out_next = out_reg;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // soft reset or a new control write drops back to idle
    if (output_unit_soft_reset_reg || wr_ctrl) begin
      state_next = ST_IDLE;
    end
  end

  // sequencer registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      out_reg <= 1'b1;
      done_cnt_reg <= 16'h0000;
      bit_idx_reg <= 4'hF;
      iter_cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      out_reg <= out_next;
      done_cnt_reg <= done_cnt_next;
      bit_idx_reg <= bit_idx_next;
      iter_cnt_reg <= iter_cnt_next;
    end
  end

  assign event_out = out_reg;

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  // soft reset is self-clearing after one cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      event_output_enable_reg <= 1'b0;
      now_reg <= 1'b0;
      casc_reg <= 1'b0;
      tail_reg <= 1'b0;
      output_unit_soft_reset_reg <= 1'b0;
      sel_reg <= SEL_RESET;
      target_reg <= '0;
      pwid_reg <= 32'h0;
      cwid_reg <= 32'h0;
      ccnt_reg <= 16'h0000;
      pat_reg <= '0;
      iter_reg <= ITER_RESET;
    end else begin
      output_unit_soft_reset_reg <= 1'b0;
      if (wr_any_cfg) begin
        case (reg_addr)
          ADDR_CTRL: begin
            event_output_enable_reg <= reg_wdata[CTRL_EN_BIT];
            now_reg <= reg_wdata[CTRL_NOW_BIT];
            casc_reg <= reg_wdata[CTRL_CASC_BIT];
            tail_reg <= reg_wdata[CTRL_TAIL_BIT];
            output_unit_soft_reset_reg <= reg_wdata[CTRL_SRST_BIT];
            sel_reg <= reg_wdata[CTRL_SEL_HI:CTRL_SEL_LO];
          end
          ADDR_TIME: target_reg <= reg_wdata[TW-1:0];
          ADDR_PWID: pwid_reg <= reg_wdata;
          ADDR_CWID: cwid_reg <= reg_wdata;
          ADDR_CCNT: begin
            ccnt_reg <= reg_wdata[31:CCNT_CNT_LO];
            pat_reg <= reg_wdata[PAT_W-1:0];
          end
          ADDR_ITER: iter_reg <= reg_wdata[15:0];
          default: begin
            pat_reg <= pat_reg;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;
  // unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0;
    case (reg_addr)
      ADDR_CTRL: begin
        rd_mux[CTRL_EN_BIT] = event_output_enable_reg;
        rd_mux[CTRL_NOW_BIT] = now_reg;
        rd_mux[CTRL_CASC_BIT] = casc_reg;
        rd_mux[CTRL_TAIL_BIT] = tail_reg;
        rd_mux[CTRL_SEL_HI:CTRL_SEL_LO] = sel_reg;
      end
      ADDR_TIME: rd_mux[TW-1:0] = target_reg;
      ADDR_PWID: rd_mux = pwid_reg;
      ADDR_CWID: rd_mux = cwid_reg;
      ADDR_CCNT: rd_mux = {ccnt_reg, pat_reg};
      ADDR_ITER: rd_mux[15:0] = iter_reg;
      ADDR_STAT: rd_mux = {11'h0, out_reg, state_reg, done_cnt_reg};
      default: rd_mux = 32'h0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 32'h0;
    end else begin
      rdata_reg <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule : pteow_core
`default_nettype wire

// ===== pteow_core_sva.sv
// checker: port-level assertions for the event output waveform block
`timescale 1ns/100ps
`default_nettype none
module pteow_core_sva
  import pteow_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // event output
  input wire logic event_out
);
  // ----------------------------------------------------------------
  // shadow of software settings
  // ----------------------------------------------------------------
  logic [2:0] sel_reg;
  logic [31:0] pw_reg;
  logic [15:0] iter_reg;
  wire logic wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
  wire logic wr_pw = reg_wr && (reg_addr == ADDR_PWID);
  wire logic wr_iter = reg_wr && (reg_addr == ADDR_ITER);

  // track what was written so shapes can be judged per selector
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= SEL_RESET;
      pw_reg <= 32'h0;
      iter_reg <= ITER_RESET;
    end else begin
      if (wr_ctrl) sel_reg <= reg_wdata[22:20];
      if (wr_pw) pw_reg <= reg_wdata;
      if (wr_iter) iter_reg <= reg_wdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_low3;
    !event_out [*3];
  endsequence
  sequence s_high3;
    event_out [*3];
  endsequence

  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside read cycle");
  a_sel_readback: assert property (reg_rd && reg_addr == ADDR_CTRL |=>
    reg_rdata[22:20] == sel_reg) else $error("selector readback wrong");
  a_iter_readback: assert property (reg_rd && reg_addr == ADDR_ITER |=>
    reg_rdata[15:0] == iter_reg) else $error("repeat count readback wrong");
  a_neg_edge_holds: assert property (sel_reg == 3'h0 && $fell(event_out)
    && !$past(wr_ctrl) |-> s_low3 ##1 s_low3)
    else $error("falling edge not held low");
  a_pos_edge_high: assert property (sel_reg == 3'h1
    && $past(sel_reg) == 3'h1 |-> event_out) else $error("rising edge low");
  a_neg_pulse_shape: assert property (sel_reg == 3'h2 && pw_reg == 32'h3
    && $fell(event_out) |-> s_low3 ##1 s_high3)
    else $error("low pulse shape wrong");
  a_pos_pulse_shape: assert property (sel_reg == 3'h3 && pw_reg == 32'h3
    && $rose(event_out) |-> s_high3 ##1 s_low3)
    else $error("high pulse shape wrong");
  a_neg_period_shape: assert property (sel_reg == 3'h4 && pw_reg == 32'h3
    && $fell(event_out) |-> s_low3 ##1 event_out [*2])
    else $error("low periodic phase wrong");
  a_pos_period_shape: assert property (sel_reg == 3'h5 && pw_reg == 32'h3
    && $rose(event_out) |-> s_high3 ##1 !event_out [*2])
    else $error("high periodic phase wrong");
  a_reserved_idle: assert property (wr_ctrl && reg_wdata[22:20] == 3'h7
    |=> event_out [*6]) else $error("reserved code left the idle level");
endmodule : pteow_core_sva

bind pteow_core pteow_core_sva i_pteow_core_sva (.ref_clk, .arst_n,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .event_out);
`default_nettype wire

// ===== pteow_rx_model.sv
// partner: receiving equipment that tallies falling edges on the line
`timescale 1ns/100ps
`default_nettype none
module pteow_rx_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // observed line
  input wire logic event_out,
  // edge tally
  output logic [15:0] fall_cnt
);
  logic last_reg;

  // edge count survives reconfiguration, so callers take differences
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      last_reg <= 1'b1;
      fall_cnt <= 16'h0000;
    end else begin
      last_reg <= event_out;
      if (last_reg && !event_out) fall_cnt <= fall_cnt + 16'h0001;
    end
  end
endmodule : pteow_rx_model
`default_nettype wire

// ===== ptp_event_output_waveform_test.sv
// testbench: register-driven runs of every waveform code
`timescale 1ns/100ps
`default_nettype none
module ptp_event_output_waveform_test
  import pteow_pkg::*;
;
  logic ref_clk;
  logic arst_n;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [31:0] sys_time;
  logic event_out;
  logic [15:0] fall_cnt;
  logic [31:0] cap;
  logic [31:0] d;
  logic [15:0] f;
  logic lvl;
  int mismatches = 0;
  int comparisons = 0;

  // design and receiving equipment
  pteow_core i_pteow_core (.ref_clk, .arst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .sys_time, .event_out);
  pteow_rx_model i_pteow_rx_model (.ref_clk, .arst_n, .event_out,
    .fall_cnt);

  // ----------------------------------------------------------------
  // bus and checking tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask : rd

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // configure, wait idle below target, then cross it and record 32 cycles
  task automatic run(input logic [31:0] ctrl, input logic [31:0] cw,
    input logic [31:0] ccnt, input logic idle);
    int n;
    @(posedge ref_clk);
    sys_time <= 32'h0;
    wr(ADDR_CWID, cw);
    wr(ADDR_CCNT, ccnt);
    wr(ADDR_CTRL, ctrl);
    repeat (3) @(negedge ref_clk);
    lvl = event_out;
    check(lvl, idle);
    @(posedge ref_clk);
    sys_time <= 32'h64;
    n = 0;
    @(negedge ref_clk);
    while (event_out === lvl && n < 8) begin
      n++;
      @(negedge ref_clk);
    end
    for (n = 0; n < 32; n++) begin
      cap = {cap[30:0], event_out};
      @(negedge ref_clk);
    end
  endtask : run

  // count falls over one 16-cycle window, one pattern loop
  task automatic falls(input logic [31:0] exp);
    f = fall_cnt;
    repeat (16) @(negedge ref_clk);
    check(fall_cnt - f, exp);
  endtask : falls

  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // whole run is well under 2000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish;
  end

  initial begin
    arst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    sys_time = 32'h0;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(ADDR_CTRL, d);
    check(d, 32'h0);
    rd(ADDR_ITER, d);
    check(d, 32'h0);
    check(event_out, 1'b1);
    wr(ADDR_ITER, 32'h1);
    rd(ADDR_ITER, d);
    check(d, 32'h1);
    rd(4'hF, d);
    check(d, 32'h0);
    wr(ADDR_TIME, 32'h64);
    wr(ADDR_PWID, 32'h3);
    run(32'h00000001, 32'h5, 32'h0, 1'b1);
    check(cap, 32'h00000000);
    run(32'h00200001, 32'h5, 32'h0, 1'b1);
    check(cap, 32'h1FFFFFFF);
    run(32'h00300001, 32'h5, 32'h0, 1'b0);
    check(cap, 32'hE0000000);
    f = fall_cnt;
    run(32'h00400001, 32'h5, 32'h00020000, 1'b1);
    check(cap, 32'h18FFFFFF);
    check(fall_cnt - f, 32'h2);
    rd(ADDR_STAT, d);
    check(d, 32'h00180002);
    run(32'h00500001, 32'h5, 32'h00020000, 1'b0);
    check(cap, 32'hE7000000);
    run(32'h00100001, 32'h5, 32'h0, 1'b1);
    check(cap, 32'hFFFFFFFF);
    run(32'h00700001, 32'h5, 32'h0, 1'b1);
    check(cap, 32'hFFFFFFFF);
    // one cycle per bit keeps the toggle rate at half the clock
    run(32'h00600001, 32'h1, 32'h00145A3C, 1'b1);
    check(cap[31:12], 20'h5A3C5);
    run(32'h0060000D, 32'h1, 32'h00005A3C, 1'b1);
    check(cap, 32'h5A3C5A3C);
    falls(32'h0);
    run(32'h00600005, 32'h1, 32'h00005A3C, 1'b1);
    check(cap, 32'h5A3C5A3C);
    falls(32'h4);
    wr(ADDR_CTRL, 32'h00000010);
    repeat (3) @(negedge ref_clk);
    check(event_out, 1'b1);
    falls(32'h0);
    @(posedge ref_clk);
    sys_time <= 32'hC8;
    wr(ADDR_CTRL, 32'h00000001);
    repeat (3) @(negedge ref_clk);
    check(event_out, 1'b1);
    wr(ADDR_CTRL, 32'h00000003);
    repeat (3) @(negedge ref_clk);
    check(event_out, 1'b0);
    repeat (8) @(negedge ref_clk);
    tally_and_finish;
  end
endmodule : ptp_event_output_waveform_test
`default_nettype wire
